// ---- pkg/cwf_defines.svh ----
// offsets, field positions, reset values for the capacity warning flags block
`ifndef CWF_DEFINES_SVH
`define CWF_DEFINES_SVH
`define CWF_OFF_CHARGE      8'h00
`define CWF_OFF_INIT_TH     8'h04
`define CWF_OFF_FSET_TH     8'h08
`define CWF_OFF_FCLR_TH     8'h0C
`define CWF_OFF_FLAGS       8'h10
`define CWF_OFF_IRQ_STAT    8'h14
`define CWF_OFF_IRQ_MASK    8'h18
`define CWF_BIT_INIT        0
`define CWF_BIT_FINAL       1
`define CWF_RST_CHARGE      16'h0000
`define CWF_RST_INIT_TH     16'h0064
`define CWF_RST_FSET_TH     16'h0032
`define CWF_RST_FCLR_TH     16'h004B
`define CWF_FINAL_DISABLE   16'hFFFF
`define CWF_RESP_OKAY       2'b00
`define CWF_RESP_SLVERR     2'b10
`endif

// ---- pkg/cwf_pkg.sv ----
// types for the capacity warning flags block
package cwf_pkg;
   // the two warning flags as carried together
   typedef struct packed {
      logic final_warning_flag;
      logic initial_warning_flag;
   } cwf_flags_t;
   // thresholds as carried together
   typedef struct packed {
      logic [15:0] initial_threshold;
      logic [15:0] final_set_threshold;
      logic [15:0] final_clear_threshold;
   } cwf_thresh_t;
   // read side states
   typedef enum logic [0:0] {
      CWF_RD_IDLE = 1'b0,
      CWF_RD_RESP = 1'b1
   } cwf_rd_state_t;
endpackage : cwf_pkg

// ---- hdl/cwf_capacity_warning.sv ----
// capacity warning flags with axi4-lite register access
// Summary of operation
// - set initial flag when remaining charge drops below initial threshold
// - clear initial flag when remaining charge rises above initial threshold
// - set final flag when remaining charge drops below final set threshold
// - final set threshold of -1 disables setting the final flag
// - clear final flag above final clear threshold unless set threshold is -1
// - both flags readable as bits of the flag status word
`timescale 1ns/1ns
`default_nettype none
`include "cwf_defines.svh"
module cwf_capacity_warning #(
   parameter int W = 16
) (
   // clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // write address channel
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output var  logic        s_axi_awready,
   // write data channel
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output var  logic        s_axi_wready,
   // write response channel
   output var  logic [1:0]  s_axi_bresp,
   output var  logic        s_axi_bvalid,
   input  wire logic        s_axi_bready,
   // read address channel
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output var  logic        s_axi_arready,
   // read data channel
   output var  logic [31:0] s_axi_rdata,
   output var  logic [1:0]  s_axi_rresp,
   output var  logic        s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // warning outputs
   output var  logic        initial_warning_flag,
   output var  logic        final_warning_flag,
   output var  logic        irq
);

   // registers
   logic [W-1:0]        charge_r;
   logic                charge_upd_r;
   cwf_pkg::cwf_thresh_t th_r;
   cwf_pkg::cwf_flags_t flags_r;
   cwf_pkg::cwf_flags_t flags_nxt;
   logic [1:0]          stat_r;
   logic [1:0]          mask_r;
   logic [7:0]          awaddr_r;
   logic                aw_held_r;
   logic [31:0]         wdata_r;
   logic [3:0]          wstrb_r;
   logic                w_held_r;

   // merge 16-bit value with the two low byte lanes
   function automatic logic [15:0] lane_merge(input logic [15:0] old,
                                              input logic [31:0] d,
                                              input logic [3:0] s);
      lane_merge = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
   endfunction : lane_merge

   // register map, byte addresses, 16-bit values in the low half:
   //   0x00 remaining charge, a write here triggers one evaluation
   //   0x04 initial threshold
   //   0x08 final set threshold, all ones (-1) disables the final flag
   //   0x0c final clear threshold
   //   0x10 flag status word, read only; a write answers okay and drops
   //   0x14 interrupt status, write one to clear
   //   0x18 interrupt mask, same layout as the status
   //   any other word answers slverr and reads as zero

   // one-hot select from a word address, shared by both decoders so that
   // reads and writes can never disagree about the map
   function automatic logic [6:0] reg_sel(input logic [7:0] a);
      reg_sel = 7'h00;
      if (a == `CWF_OFF_CHARGE)
         reg_sel = 7'h01;
      else if (a == `CWF_OFF_INIT_TH)
         reg_sel = 7'h02;
      else if (a == `CWF_OFF_FSET_TH)
         reg_sel = 7'h04;
      else if (a == `CWF_OFF_FCLR_TH)
         reg_sel = 7'h08;
      else if (a == `CWF_OFF_FLAGS)
         reg_sel = 7'h10;
      else if (a == `CWF_OFF_IRQ_STAT)
         reg_sel = 7'h20;
      else if (a == `CWF_OFF_IRQ_MASK)
         reg_sel = 7'h40;
   endfunction : reg_sel

   // write fires once both address and data are held and no response pends
   wire        wr_go   = aw_held_r && w_held_r && !s_axi_bvalid;
   wire [6:0]  wsel    = reg_sel(awaddr_r);
   wire        wr_chg  = wr_go && wsel[0];
   wire        wr_ith  = wr_go && wsel[1];
   wire        wr_fst  = wr_go && wsel[2];
   wire        wr_fcl  = wr_go && wsel[3];
   wire        wr_sts  = wr_go && wsel[5];
   wire        wr_msk  = wr_go && wsel[6];
   // flag word writes are accepted with okay and change nothing
   wire        wr_hit  = wr_go && (wsel != 7'h00);

   // signed comparisons, only looked at on a charge update
   // two's complement, so a gauge that reports an overdrawn (negative)
   // charge still reads as below every positive threshold
   // limitation: a threshold write alone does not re-evaluate; the new
   // level takes effect at the next remaining charge write
   // equal to a threshold is neither set nor clear, so the flag holds
   wire signed [15:0] chg_s = charge_r;
   wire signed [15:0] ith_s = th_r.initial_threshold;
   wire signed [15:0] fst_s = th_r.final_set_threshold;
   wire signed [15:0] fcl_s = th_r.final_clear_threshold;
   wire fin_off  = (th_r.final_set_threshold == `CWF_FINAL_DISABLE);
   wire ini_set  = chg_s < ith_s;
   wire ini_clr  = chg_s > ith_s;
   // final set test, blocked at -1
   wire fin_set  = (chg_s < fst_s) && !fin_off;
   // final clear test, blocked at -1
   wire fin_clr  = (chg_s > fcl_s) && !fin_off && flags_r.final_warning_flag;

   // next flags on update, else hold
   always_comb begin
      flags_nxt = flags_r;
      if (charge_upd_r) begin
         if (ini_set)
            flags_nxt.initial_warning_flag = 1'b1;
         else if (ini_clr)
            flags_nxt.initial_warning_flag = 1'b0;
         if (fin_set)
            flags_nxt.final_warning_flag = 1'b1;
         else if (fin_clr)
            flags_nxt.final_warning_flag = 1'b0;
      end
   end

   // rising flag edges are the interrupt events
   // a falling flag leaves its status bit alone, so software still sees
   // a warning that came and went while it was not looking
   wire [1:0] ev = {flags_nxt.final_warning_flag
                    & ~flags_r.final_warning_flag,
                    flags_nxt.initial_warning_flag
                    & ~flags_r.initial_warning_flag};
   // write-one clears, but a same-cycle event wins
   wire [1:0] w1c = wr_sts ? (wdata_r[1:0] & {2{wstrb_r[0]}}) : 2'b00;
   wire [1:0] stat_nxt = (stat_r & ~w1c) | ev;

   // register writes and flag update
   // byte lanes 0 and 1 are honoured; status and mask use lane 0 only
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         charge_r     <= `CWF_RST_CHARGE;
         charge_upd_r <= 1'b0;
         th_r         <= {`CWF_RST_INIT_TH, `CWF_RST_FSET_TH,
                          `CWF_RST_FCLR_TH};
         flags_r      <= '0;
         stat_r       <= 2'b00;
         mask_r       <= 2'b00;
      end else begin
         charge_upd_r <= wr_chg;
         flags_r      <= flags_nxt;
         stat_r       <= stat_nxt;
         if (wr_chg)
            charge_r <= lane_merge(charge_r, wdata_r, wstrb_r);
         if (wr_ith)
            th_r.initial_threshold <=
               lane_merge(th_r.initial_threshold, wdata_r, wstrb_r);
         if (wr_fst)
            th_r.final_set_threshold <=
               lane_merge(th_r.final_set_threshold, wdata_r, wstrb_r);
         if (wr_fcl)
            th_r.final_clear_threshold <=
               lane_merge(th_r.final_clear_threshold, wdata_r, wstrb_r);
         if (wr_msk && wstrb_r[0])
            mask_r <= wdata_r[1:0];
      end
   end

   // outputs straight from flops
   // pins launch on the same edge as the flag word, so they never differ
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         initial_warning_flag <= 1'b0;
         final_warning_flag   <= 1'b0;
         irq                  <= 1'b0;
      end else begin
         initial_warning_flag <= flags_nxt.initial_warning_flag;
         final_warning_flag   <= flags_nxt.final_warning_flag;
         irq                  <= |(stat_nxt & mask_r);
      end
   end

   // write timing: ready pulses the cycle after valid is seen, each half
   // is held until both are in, then bvalid rises one cycle later; a new
   // pair reaches the registers only after the previous response is
   // accepted, so one write at a time is ever applied
   // write channel capture, address and data in either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_r     <= 1'b0;
         w_held_r      <= 1'b0;
         awaddr_r      <= 8'h00;
         wdata_r       <= 32'h0000_0000;
         wstrb_r       <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= `CWF_RESP_OKAY;
      end else begin
         s_axi_awready <= !aw_held_r && !s_axi_awready && s_axi_awvalid;
         s_axi_wready  <= !w_held_r && !s_axi_wready && s_axi_wvalid;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held_r <= 1'b1;
            awaddr_r  <= {s_axi_awaddr[7:2], 2'b00};
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held_r <= 1'b1;
            wdata_r  <= s_axi_wdata;
            wstrb_r  <= s_axi_wstrb;
         end
         if (wr_go) begin
            aw_held_r    <= 1'b0;
            w_held_r     <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_hit ? `CWF_RESP_OKAY : `CWF_RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // read decode
   wire [7:0] ra   = {s_axi_araddr[7:2], 2'b00};
   wire [6:0] rsel = reg_sel(ra);
   logic [31:0] rd_val;
   logic        rd_ok;
   always_comb begin
      rd_ok  = 1'b1;
      if (rsel[0])
         rd_val = {16'h0000, charge_r};
      else if (rsel[1])
         rd_val = {16'h0000, th_r.initial_threshold};
      else if (rsel[2])
         rd_val = {16'h0000, th_r.final_set_threshold};
      else if (rsel[3])
         rd_val = {16'h0000, th_r.final_clear_threshold};
      else if (rsel[4])
         rd_val = {30'h0000_0000, flags_r};
      else if (rsel[5])
         rd_val = {30'h0000_0000, stat_r};
      else if (rsel[6])
         rd_val = {30'h0000_0000, mask_r};
      else begin
         rd_val = 32'h0000_0000;
         rd_ok  = 1'b0;
      end
   end

   // read timing: arready the cycle after arvalid, data the cycle after;
   // rdata is captured at acceptance, so a write landing while rvalid
   // stands cannot change the answer already on the bus
   // read channel: accept, then answer next cycle
   cwf_pkg::cwf_rd_state_t rd_st_r;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rd_st_r       <= cwf_pkg::CWF_RD_IDLE;
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= `CWF_RESP_OKAY;
      end else begin
         case (rd_st_r)
            cwf_pkg::CWF_RD_IDLE: begin
               s_axi_arready <= s_axi_arvalid && !s_axi_arready;
               if (s_axi_arvalid && s_axi_arready) begin
                  s_axi_arready <= 1'b0;
                  s_axi_rvalid  <= 1'b1;
                  s_axi_rdata   <= rd_val;
                  s_axi_rresp   <= rd_ok ? `CWF_RESP_OKAY
                                         : `CWF_RESP_SLVERR;
                  rd_st_r       <= cwf_pkg::CWF_RD_RESP;
               end
            end
            cwf_pkg::CWF_RD_RESP: begin
               if (s_axi_rready) begin
                  s_axi_rvalid <= 1'b0;
                  rd_st_r      <= cwf_pkg::CWF_RD_IDLE;
               end
            end
            default: rd_st_r <= cwf_pkg::CWF_RD_IDLE;
         endcase
      end
   end

endmodule : cwf_capacity_warning
`default_nettype wire

// ---- sim/cwf_monitor.sv ----
// assertion checker on the warning block ports
`timescale 1ns/1ns
`default_nettype none
module cwf_monitor (
   // clock and reset
   input wire logic        aclk,
   input wire logic        aresetn,
   // bus handshakes
   input wire logic        s_axi_awready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic        s_axi_rvalid,
   // warning outputs
   input wire logic        initial_warning_flag,
   input wire logic        final_warning_flag,
   input wire logic        irq
);
   logic [2:0] since_r;
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // cycles since a write answer; saturates so old writes excuse nothing
   always_ff @(posedge aclk) begin
      if (!aresetn)
         since_r <= 3'h7;
      else if (s_axi_bvalid)
         since_r <= 3'h0;
      else if (since_r != 3'h7)
         since_r <= since_r + 3'h1;
   end
   // bus timing around every register access
   a_awready_pulse: assert property (
      s_axi_awready |=> !s_axi_awready) else $error("awready held");
   a_write_answer: assert property (
      s_axi_awready |-> ##[1:3] s_axi_bvalid) else $error("no bvalid");
   a_bvalid_once: assert property (
      s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("bvalid");
   a_read_answer: assert property (
      s_axi_arready |=> s_axi_rvalid) else $error("rvalid late");
   a_bresp_legal: assert property (
      s_axi_bvalid |-> !s_axi_bresp[0]) else $error("bad bresp");
   a_rdata_upper: assert property (
      s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000) else $error("rdata");
   // flags and irq move only shortly after a register write
   a_flag_cause: assert property (
      $changed({final_warning_flag, initial_warning_flag})
      |-> since_r < 3'h4) else $error("flag moved unprompted");
   a_irq_cause: assert property (
      $changed(irq) |-> s_axi_bvalid || since_r < 3'h5)
      else $error("irq moved unprompted");
endmodule : cwf_monitor
`default_nettype wire

// ---- sim/cwf_host_model.sv ----
// bus master model of the host reading the warning block
`timescale 1ns/1ns
`default_nettype none
module cwf_host_model (
   // clock
   input wire logic         aclk,
   // write channels
   output var logic [7:0]  s_axi_awaddr,
   output var logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   output var logic [31:0] s_axi_wdata,
   output var logic [3:0]  s_axi_wstrb,
   output var logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_bvalid,
   output var logic        s_axi_bready,
   // read channels
   output var logic [7:0]  s_axi_araddr,
   output var logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0]  s_axi_rresp,
   input wire logic        s_axi_rvalid,
   output var logic        s_axi_rready
);
   // idle bus at time zero; whole words only
   initial begin
      {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid} = '0;
      {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
      s_axi_wstrb = 4'hF;
   end
   // write: released lines show the inverse so stale data cannot match
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     output logic [1:0] r);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready) begin
            s_axi_awvalid <= 1'b0;
            s_axi_awaddr <= ~a;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            s_axi_wvalid <= 1'b0;
            s_axi_wdata <= ~d;
         end
      end while (!s_axi_bvalid);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask : wr
   // read: hold the address until taken, rready until the answer
   task automatic rd(input logic [7:0] a, output logic [31:0] d,
                     output logic [1:0] r);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arvalid <= 1'b0;
            s_axi_araddr <= ~a;
         end
      end while (!s_axi_rvalid);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask : rd
endmodule : cwf_host_model
`default_nettype wire

// ---- sim/cwf_capacity_warning_bench.sv ----
// self-checking bench for the capacity warning flags block
`timescale 1ns/1ns
`default_nettype none
`include "cwf_defines.svh"
module cwf_capacity_warning_bench;
   logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
   logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
   logic s_axi_arready, s_axi_rvalid, s_axi_rready, irq;
   logic initial_warning_flag, final_warning_flag;
   logic [7:0]  s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, rdat;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
   int          fails = 0, compares = 0, cycles = 0;
   cwf_capacity_warning uut (.*);
   cwf_host_model host (.*);
   // clock, 10 ns period
   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end
   // hang guard: the sequence needs well under a thousand cycles
   always @(posedge aclk) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         fails = fails + 1;
         close_out();
      end
   end
   task automatic close_out();
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : close_out
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         fails++;
         $display("ERROR at %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic rchk(input logic [7:0] a, input logic [31:0] e,
                       input logic [1:0] er);
      host.rd(a, rdat, resp);
      chk(rdat, e);
      chk({30'h0, resp}, {30'h0, er});
   endtask : rchk
   // charge update, then flag word and pins must agree with f
   task automatic step(input logic [15:0] q, input logic [1:0] f);
      host.wr(`CWF_OFF_CHARGE, {16'h0000, q}, resp);
      rchk(`CWF_OFF_FLAGS, {30'h0, f}, `CWF_RESP_OKAY);
      chk({30'h0, final_warning_flag, initial_warning_flag}, {30'h0, f});
   endtask : step
   initial begin
      aresetn = 1'b0;
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      rchk(`CWF_OFF_INIT_TH, {16'h0, `CWF_RST_INIT_TH}, 2'b00);
      rchk(`CWF_OFF_FSET_TH, {16'h0, `CWF_RST_FSET_TH}, 2'b00);
      rchk(`CWF_OFF_FCLR_TH, {16'h0, `CWF_RST_FCLR_TH}, 2'b00);
      host.wr(`CWF_OFF_IRQ_MASK, 32'h0000_0003, resp);
      chk({30'h0, resp}, {30'h0, `CWF_RESP_OKAY});
      rchk(`CWF_OFF_IRQ_MASK, 32'h0000_0003, `CWF_RESP_OKAY);
      step(16'h0078, 2'b00);
      step(16'h0064, 2'b00);
      step(16'h0063, 2'b01);
      chk({31'h0, irq}, 32'h1);
      step(16'h0031, 2'b11);
      // final clears only above its clear level
      step(16'h003C, 2'b11);
      step(16'h004C, 2'b01);
      // flag word is read only: a write answers okay and changes nothing
      host.wr(`CWF_OFF_FLAGS, 32'h0000_0002, resp);
      chk({30'h0, resp}, {30'h0, `CWF_RESP_OKAY});
      rchk(`CWF_OFF_FLAGS, 32'h0000_0001, `CWF_RESP_OKAY);
      step(16'h0065, 2'b00);
      step(16'hFFF0, 2'b11);
      rchk(`CWF_OFF_CHARGE, 32'h0000_FFF0, `CWF_RESP_OKAY);
      rchk(`CWF_OFF_IRQ_STAT, 32'h0000_0003, 2'b00);
      host.wr(`CWF_OFF_IRQ_STAT, 32'h0000_0003, resp);
      rchk(`CWF_OFF_IRQ_STAT, 32'h0000_0000, 2'b00);
      chk({31'h0, irq}, 32'h0);
      // disabled set level freezes the final flag
      host.wr(`CWF_OFF_FSET_TH, {16'h0, `CWF_FINAL_DISABLE}, resp);
      step(16'h00C8, 2'b10);
      host.wr(`CWF_OFF_FSET_TH, 32'h0000_0032, resp);
      step(16'h00C8, 2'b00);
      // disabled set level never raises it; masked event keeps irq low
      host.wr(`CWF_OFF_FSET_TH, {16'h0, `CWF_FINAL_DISABLE}, resp);
      host.wr(`CWF_OFF_IRQ_MASK, 32'h0000_0002, resp);
      step(16'hFFF0, 2'b01);
      chk({31'h0, irq}, 32'h0);
      // unmapped place answers with an error
      rchk(8'h1C, 32'h0000_0000, `CWF_RESP_SLVERR);
      host.wr(8'h1C, 32'h0000_0001, resp);
      chk({30'h0, resp}, {30'h0, `CWF_RESP_SLVERR});
      close_out();
   end
endmodule : cwf_capacity_warning_bench
bind cwf_capacity_warning cwf_monitor mon (.*);
`default_nettype wire
